// >>> usd_pkg.sv
// constants and types shared by the shadow data buffer block
package usd_pkg;

   // character path
   localparam int DATA_W     = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int PTR_W      = $clog2(FIFO_DEPTH);
   localparam int CNT_W      = PTR_W + 1;

   // register map, byte addresses on a 32-bit bus
   localparam logic [31:0] SHADOW_FIRST_ADDR = 32'h5000_1130;
   localparam logic [31:0] SHADOW_DATA1_ADDR = 32'h5000_1134;
   localparam logic [31:0] SHADOW_LAST_ADDR  = 32'h5000_116C;
   localparam logic [31:0] CTRL_ADDR         = 32'h5000_1180;
   localparam logic [31:0] LINE_STATUS_ADDR  = 32'h5000_1184;
   localparam logic [31:0] INT_STATUS_ADDR   = 32'h5000_1188;
   localparam logic [31:0] INT_MASK_ADDR     = 32'h5000_118C;
   localparam logic [31:0] DIVISOR_ADDR      = 32'h5000_1190;

   // fifo_control / mode bits of the control register
   localparam int CTRL_FIFO_EN = 0;
   localparam int CTRL_IR_MODE = 1;
   localparam int CTRL_W       = 2;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;

   // line_status bits
   localparam int LS_DATA_READY = 0;
   localparam int LS_OVERRUN    = 1;
   localparam int LS_TX_EMPTY   = 5;
   localparam int LS_TEMT       = 6;
   localparam int LS_W          = 8;

   // interrupt status / mask bits
   localparam int INT_RX      = 0;
   localparam int INT_OVERRUN = 1;
   localparam int INT_TX      = 2;
   localparam int INT_W       = 3;
   localparam logic [INT_W-1:0] INT_RESET = 3'h0;

   // baud generation, 16 ticks per bit
   localparam int DIV_W = 16;
   localparam logic [DIV_W-1:0] DIV_RESET   = 16'h000D;
   localparam logic [3:0]       TICK_LAST   = 4'hF;
   localparam logic [3:0]       TICK_MID    = 4'h7;
   localparam logic [3:0]       IR_PULSE_END = 4'h2;
   localparam logic [4:0]       IR_STRETCH  = 5'h10;
   localparam logic [2:0]       BIT_LAST    = 3'h7;

   typedef enum logic [1:0] {SER_IDLE, SER_START, SER_DATA, SER_STOP} usd_ser_state_t;

endpackage : usd_pkg

// >>> usd_fifo_if.sv
// push/pop port bundle between the top and its character fifos
`timescale 1ns/1ps
interface usd_fifo_if;
   logic                      flush;
   logic                      wrValid;
   logic                      wrReady;
   logic [usd_pkg::DATA_W-1:0] wrData;
   logic                      rdValid;
   logic                      rdReady;
   logic [usd_pkg::DATA_W-1:0] rdData;
   logic [usd_pkg::CNT_W-1:0]  count;

   modport store (input flush, wrValid, wrData, rdReady, output wrReady, rdValid, rdData, count);
   modport user  (output flush, wrValid, wrData, rdReady, input wrReady, rdValid, rdData, count);
endinterface : usd_fifo_if

// >>> usd_fifo.sv
// character fifo; full refuses pushes, contents stay untouched
`timescale 1ns/1ps
module usd_fifo (
   // clock and control
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic ce,
   // push and pop
   usd_fifo_if.store port
);
   logic [usd_pkg::DATA_W-1:0] mem [usd_pkg::FIFO_DEPTH];
   logic [usd_pkg::PTR_W-1:0]  wrPtr_q;
   logic [usd_pkg::PTR_W-1:0]  rdPtr_q;
   logic [usd_pkg::CNT_W-1:0]  count_q;
   logic                      push;
   logic                      pop;

   assign port.wrReady = (count_q != usd_pkg::CNT_W'(usd_pkg::FIFO_DEPTH));
   assign port.rdValid = (count_q != '0);
   assign port.rdData  = mem[rdPtr_q];
   assign port.count   = count_q;
   assign push = port.wrValid & port.wrReady & ~port.flush;
   assign pop  = port.rdReady & port.rdValid & ~port.flush;

   always_ff @(posedge clk_sys)
   begin
      if (ce && push)
      begin
         mem[wrPtr_q] <= port.wrData;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst || (ce && port.flush))
      begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end
      else if (ce)
      begin
         wrPtr_q <= wrPtr_q + usd_pkg::PTR_W'(push);
         rdPtr_q <= rdPtr_q + usd_pkg::PTR_W'(pop);
         count_q <= count_q + usd_pkg::CNT_W'(push) - usd_pkg::CNT_W'(pop);
      end
   end
endmodule : usd_fifo

// >>> usd_sync.sv
// two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module usd_sync #(
   parameter logic RST_VAL = 1'b1
) (
   // clock and control
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic ce,
   // pin and synchronised level
   input  wire logic d,
   output logic      q
);
   logic meta_q;

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         meta_q <= RST_VAL;
         q      <= RST_VAL;
      end
      else if (ce)
      begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : usd_sync

// >>> usd_shadow_uart.sv
// uart data path behind the shadow receive/transmit data locations
// What this block does
// - Sixteen 32-bit word locations all alias one shadow of the receive buffer and transmit holding register.
// - Reading the low byte returns the character received on the serial input, or the infrared input in ir mode.
// - The returned character is valid only while the data-ready bit of line status is set.
// - Without fifos a new character overwrites an unread receive buffer and raises overrun.
// - With fifos enabled a read returns and removes the head of the receive fifo.
// - A character arriving at a full receive fifo is dropped, the fifo is kept and overrun is raised.
// - Writing the low byte queues a character for the serial output, or the active-low infrared output in ir mode.
// - Without fifos a write while transmit holding is empty clears the transmit-holding-empty bit.
// - Without fifos further writes before the bit sets again overwrite the pending holding data.
// - With fifos the transmit path accepts writes up to a depth of sixteen characters.
// - A transmit write while the transmit fifo is full is dropped and the fifo is unchanged.
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module usd_shadow_uart (
   // clock, reset, enable
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        ce,
   // avalon-mm slave
   input  wire logic [31:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // serial line
   input  wire logic        sin,
   input  wire logic        sir_in,
   output logic             sout,
   output logic             sirOutN,
   // interrupt
   output logic             irq
);
   // shadow window decode, shared by reads and writes
   function automatic logic isShadow(input logic [31:0] addr);
      isShadow = (addr >= usd_pkg::SHADOW_FIRST_ADDR) && (addr <= usd_pkg::SHADOW_LAST_ADDR)
                 && (addr[1:0] == 2'h0);
   endfunction : isShadow

   usd_fifo_if rxFifo ();
   usd_fifo_if txFifo ();

   logic                        ack_q;
   logic [31:0]                 readData_q;
   logic [usd_pkg::CTRL_W-1:0]  ctrl_q;
   logic [usd_pkg::DIV_W-1:0]   divisor_q;
   logic [usd_pkg::INT_W-1:0]   intStatus_q;
   logic [usd_pkg::INT_W-1:0]   intMask_q;
   logic                        overrun_q;
   logic [usd_pkg::DATA_W-1:0]  rxHold_q;
   logic                        rxHoldValid_q;
   logic [usd_pkg::DATA_W-1:0]  txHold_q;
   logic                        txHoldFull_q;
   logic                        txEmptyPrev_q;
   logic [usd_pkg::DIV_W-1:0]   divCnt_q;
   logic                        tick;
   logic                        sinSync;
   logic                        sirSync;
   logic [4:0]                  irStretch_q;
   logic                        rxLine;
   usd_pkg::usd_ser_state_t     rxState_q;
   logic [3:0]                  rxTick_q;
   logic [2:0]                  rxBit_q;
   logic [usd_pkg::DATA_W-1:0]  rxShift_q;
   logic                        rxDeliver;
   usd_pkg::usd_ser_state_t     txState_q;
   logic [3:0]                  txTick_q;
   logic [2:0]                  txBit_q;
   logic [usd_pkg::DATA_W-1:0]  txShift_q;
   logic                        txLine;
   logic                        txHeadValid;
   logic [usd_pkg::DATA_W-1:0]  txHead;
   logic                        txLoad;
   logic                        fifoEn;
   logic                        irMode;
   logic                        doRead;
   logic                        doWrite;
   logic                        shadowPop;
   logic                        shadowPush;
   logic                        ctrlWrite;
   logic                        dataReady;
   logic                        txHoldEmpty;
   logic                        rxOverflow;
   logic                        rxStored;
   logic [usd_pkg::INT_W-1:0]   intEvents;
   logic [usd_pkg::LS_W-1:0]    lineStatus;
   logic [usd_pkg::DATA_W-1:0]  rxHead;
   logic [31:0]                 readMux;

   assign fifoEn = ctrl_q[usd_pkg::CTRL_FIFO_EN];
   assign irMode = ctrl_q[usd_pkg::CTRL_IR_MODE];

   // bus slave: one wait cycle, then the answer edge
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign avs_readdata    = readData_q;
   assign doRead          = ce & avs_read & ack_q;
   assign doWrite         = ce & avs_write & ack_q;
   assign shadowPop       = doRead & isShadow(avs_address);
   // only the low byte lane carries a character
   assign shadowPush      = doWrite & isShadow(avs_address) & avs_byteenable[0];
   assign ctrlWrite       = doWrite & (avs_address == usd_pkg::CTRL_ADDR) & avs_byteenable[0];

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         ack_q <= 1'b0;
      end
      else if (ce)
      begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
      end
   end

   // head of fifo or single buffer, chosen by fifo_control
   assign rxHead    = fifoEn ? rxFifo.rdData : rxHold_q;
   assign dataReady = fifoEn ? rxFifo.rdValid : rxHoldValid_q;
   assign txHoldEmpty = fifoEn ? ~txFifo.rdValid : ~txHoldFull_q;

   always_comb
   begin
      lineStatus = '0;
      lineStatus[usd_pkg::LS_DATA_READY] = dataReady;
      lineStatus[usd_pkg::LS_OVERRUN]    = overrun_q;
      lineStatus[usd_pkg::LS_TX_EMPTY]   = txHoldEmpty;
      lineStatus[usd_pkg::LS_TEMT]       = txHoldEmpty & (txState_q == usd_pkg::SER_IDLE);
   end

   always_comb
   begin
      readMux = 32'h0000_0000;
      if (isShadow(avs_address))
      begin
         readMux[usd_pkg::DATA_W-1:0] = rxHead;
      end
      else if (avs_address == usd_pkg::CTRL_ADDR)
      begin
         readMux[usd_pkg::CTRL_W-1:0] = ctrl_q;
      end
      else if (avs_address == usd_pkg::LINE_STATUS_ADDR)
      begin
         readMux[usd_pkg::LS_W-1:0] = lineStatus;
      end
      else if (avs_address == usd_pkg::INT_STATUS_ADDR)
      begin
         readMux[usd_pkg::INT_W-1:0] = intStatus_q;
      end
      else if (avs_address == usd_pkg::INT_MASK_ADDR)
      begin
         readMux[usd_pkg::INT_W-1:0] = intMask_q;
      end
      else if (avs_address == usd_pkg::DIVISOR_ADDR)
      begin
         readMux[usd_pkg::DIV_W-1:0] = divisor_q;
      end
   end

   // data captured on the wait cycle, held through the answer edge
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         readData_q <= 32'h0000_0000;
      end
      else if (ce && avs_read && !ack_q)
      begin
         readData_q <= readMux;
      end
   end

   // configuration registers
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         ctrl_q    <= usd_pkg::CTRL_RESET;
         divisor_q <= usd_pkg::DIV_RESET;
         intMask_q <= usd_pkg::INT_RESET;
      end
      else if (doWrite)
      begin
         if (ctrlWrite)
         begin
            ctrl_q <= avs_writedata[usd_pkg::CTRL_W-1:0];
         end
         if (avs_address == usd_pkg::DIVISOR_ADDR && avs_byteenable[1:0] == 2'h3)
         begin
            divisor_q <= avs_writedata[usd_pkg::DIV_W-1:0];
         end
         if (avs_address == usd_pkg::INT_MASK_ADDR && avs_byteenable[0])
         begin
            intMask_q <= avs_writedata[usd_pkg::INT_W-1:0];
         end
      end
   end

   // switching fifo mode flushes both fifos so no stale characters mix in
   assign rxFifo.flush = ctrlWrite & (avs_writedata[usd_pkg::CTRL_FIFO_EN] != fifoEn);
   assign txFifo.flush = rxFifo.flush;

   // baud tick, sixteen per bit
   assign tick = (divCnt_q == '0);

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         divCnt_q <= usd_pkg::DIV_RESET;
      end
      else if (ce)
      begin
         divCnt_q <= tick ? divisor_q : divCnt_q - usd_pkg::DIV_W'(1);
      end
   end

   usd_sync #(.RST_VAL(1'b1)) u_sinSync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .ce      (ce),
      .d       (sin),
      .q       (sinSync)
   );

   usd_sync #(.RST_VAL(1'b0)) u_sirSync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .ce      (ce),
      .d       (sir_in),
      .q       (sirSync)
   );

   // ir pulses are short, so each one is stretched to a full bit of low level
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         irStretch_q <= '0;
      end
      else if (ce)
      begin
         if (sirSync)
         begin
            irStretch_q <= usd_pkg::IR_STRETCH;
         end
         else if (tick && irStretch_q != '0)
         begin
            irStretch_q <= irStretch_q - 5'h01;
         end
      end
   end

   assign rxLine = irMode ? (irStretch_q == '0) : sinSync;

   // receiver: start, eight data bits lsb first, stop
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         rxState_q <= usd_pkg::SER_IDLE;
         rxTick_q  <= '0;
         rxBit_q   <= '0;
         rxShift_q <= '0;
      end
      else if (ce && tick)
      begin
         rxTick_q <= rxTick_q + 4'h1;
         unique case (rxState_q)
            usd_pkg::SER_IDLE:
            begin
               rxTick_q <= '0;
               if (!rxLine)
               begin
                  rxState_q <= usd_pkg::SER_START;
               end
            end
            usd_pkg::SER_START:
            begin
               if (rxTick_q == usd_pkg::TICK_MID)
               begin
                  rxTick_q  <= '0;
                  rxBit_q   <= '0;
                  rxState_q <= rxLine ? usd_pkg::SER_IDLE : usd_pkg::SER_DATA;
               end
            end
            usd_pkg::SER_DATA:
            begin
               if (rxTick_q == usd_pkg::TICK_LAST)
               begin
                  rxShift_q <= {rxLine, rxShift_q[usd_pkg::DATA_W-1:1]};
                  rxBit_q   <= rxBit_q + 3'h1;
                  if (rxBit_q == usd_pkg::BIT_LAST)
                  begin
                     rxState_q <= usd_pkg::SER_STOP;
                  end
               end
            end
            usd_pkg::SER_STOP:
            begin
               if (rxTick_q == usd_pkg::TICK_LAST)
               begin
                  rxState_q <= usd_pkg::SER_IDLE;
               end
            end
         endcase
      end
   end

   // a character with a bad stop bit is dropped
   assign rxDeliver = ce & tick & (rxState_q == usd_pkg::SER_STOP) & (rxTick_q == usd_pkg::TICK_LAST) & rxLine;

   // full fifo refuses the push, contents kept
   assign rxFifo.wrValid = rxDeliver & fifoEn;
   assign rxFifo.wrData  = rxShift_q;
   assign rxFifo.rdReady = shadowPop & fifoEn;
   assign rxOverflow = fifoEn ? (rxDeliver & ~rxFifo.wrReady) : (rxDeliver & rxHoldValid_q & ~shadowPop);
   assign rxStored   = rxDeliver & ~rxOverflow;

   usd_fifo u_rxFifo (
      .clk_sys (clk_sys),
      .rst     (rst),
      .ce      (ce),
      .port    (rxFifo.store)
   );

   // single buffer is overwritten, valid set wins over the read
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         rxHold_q      <= '0;
         rxHoldValid_q <= 1'b0;
      end
      else if (ce)
      begin
         if (rxDeliver && !fifoEn)
         begin
            rxHold_q      <= rxShift_q;
            rxHoldValid_q <= 1'b1;
         end
         else if (shadowPop || fifoEn)
         begin
            rxHoldValid_q <= 1'b0;
         end
      end
   end

   // overrun sticks until line status is read; a new one wins
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         overrun_q <= 1'b0;
      end
      else if (ce)
      begin
         if (rxOverflow)
         begin
            overrun_q <= 1'b1;
         end
         else if (doRead && avs_address == usd_pkg::LINE_STATUS_ADDR)
         begin
            overrun_q <= 1'b0;
         end
      end
   end

   // fifo accepts up to its depth
   // a push at full is simply refused
   assign txFifo.wrValid = shadowPush & fifoEn;
   assign txFifo.wrData  = avs_writedata[usd_pkg::DATA_W-1:0];
   assign txHeadValid    = fifoEn ? txFifo.rdValid : txHoldFull_q;
   assign txHead         = fifoEn ? txFifo.rdData : txHold_q;
   assign txLoad         = ce & (txState_q == usd_pkg::SER_IDLE) & txHeadValid;
   assign txFifo.rdReady = txLoad & fifoEn;

   usd_fifo u_txFifo (
      .clk_sys (clk_sys),
      .rst     (rst),
      .ce      (ce),
      .port    (txFifo.store)
   );

   // a write fills the holding register and clears its empty flag
   // a later write before the load overwrites it
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         txHold_q     <= '0;
         txHoldFull_q <= 1'b0;
      end
      else if (ce)
      begin
         if (shadowPush && !fifoEn)
         begin
            txHold_q     <= avs_writedata[usd_pkg::DATA_W-1:0];
            txHoldFull_q <= 1'b1;
         end
         else if (txLoad || fifoEn)
         begin
            txHoldFull_q <= 1'b0;
         end
      end
   end

   // transmitter: idle loads, then start, data, stop on baud ticks
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         txState_q <= usd_pkg::SER_IDLE;
         txTick_q  <= '0;
         txBit_q   <= '0;
         txShift_q <= '0;
      end
      else if (txLoad)
      begin
         txState_q <= usd_pkg::SER_START;
         txTick_q  <= '0;
         txBit_q   <= '0;
         txShift_q <= txHead;
      end
      else if (ce && tick && txState_q != usd_pkg::SER_IDLE)
      begin
         txTick_q <= txTick_q + 4'h1;
         if (txTick_q == usd_pkg::TICK_LAST)
         begin
            unique case (txState_q)
               usd_pkg::SER_START: txState_q <= usd_pkg::SER_DATA;
               usd_pkg::SER_DATA:
               begin
                  txShift_q <= txShift_q >> 1;
                  txBit_q   <= txBit_q + 3'h1;
                  if (txBit_q == usd_pkg::BIT_LAST)
                  begin
                     txState_q <= usd_pkg::SER_STOP;
                  end
               end
               usd_pkg::SER_STOP:  txState_q <= usd_pkg::SER_IDLE;
               usd_pkg::SER_IDLE:  txState_q <= usd_pkg::SER_IDLE;
            endcase
         end
      end
   end

   assign txLine = (txState_q == usd_pkg::SER_START) ? 1'b0
                 : (txState_q == usd_pkg::SER_DATA)  ? txShift_q[0] : 1'b1;

   // uart line idles high in ir mode; ir pulse is 3/16 of a zero bit
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         sout    <= 1'b1;
         sirOutN <= 1'b1;
      end
      else if (ce)
      begin
         sout    <= irMode | txLine;
         sirOutN <= ~(irMode & ~txLine & (txTick_q <= usd_pkg::IR_PULSE_END));
      end
   end

   // interrupt events: character stored, overrun, holding register drained
   always_comb
   begin
      intEvents = '0;
      intEvents[usd_pkg::INT_RX]      = rxStored;
      intEvents[usd_pkg::INT_OVERRUN] = rxOverflow;
      intEvents[usd_pkg::INT_TX]      = ce & txHoldEmpty & ~txEmptyPrev_q;
   end

   // write-one-to-clear, a same-cycle event wins
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         intStatus_q   <= usd_pkg::INT_RESET;
         txEmptyPrev_q <= 1'b1;
      end
      else if (ce)
      begin
         txEmptyPrev_q <= txHoldEmpty;
         if (doWrite && avs_address == usd_pkg::INT_STATUS_ADDR && avs_byteenable[0])
         begin
            intStatus_q <= (intStatus_q & ~avs_writedata[usd_pkg::INT_W-1:0]) | intEvents;
         end
         else
         begin
            intStatus_q <= intStatus_q | intEvents;
         end
      end
   end

   // level from registered status and mask, no extra latency
   assign irq = |(intStatus_q & intMask_q);

endmodule : usd_shadow_uart

// >>> usd_shadow_uart_props.sv
// checker on the shadow uart top ports
`timescale 1ns/1ps
module usd_shadow_uart_props (
   // clock, reset
   input wire logic        clk_sys,
   input wire logic        rst,
   // bus
   input wire logic [31:0] avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // line, interrupt
   input wire logic        sout,
   input wire logic        sirOutN,
   input wire logic        irq
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire ans = avs_read && !avs_waitrequest;
   property p_one_wait; $rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
   a_one_wait: assert property (p_one_wait) else $error("answer not after one wait");
   property p_short_wait; avs_waitrequest |=> !avs_waitrequest; endproperty
   a_short_wait: assert property (p_short_wait) else $error("wait longer than one cycle");
   property p_idle; !(avs_read | avs_write) |-> !avs_waitrequest; endproperty
   a_idle: assert property (p_idle) else $error("wait while idle");
   property p_upper; ans && avs_address >= usd_pkg::SHADOW_FIRST_ADDR
      && avs_address <= usd_pkg::SHADOW_LAST_ADDR |-> avs_readdata[31:8] == 24'h0; endproperty
   a_upper: assert property (p_upper) else $error("shadow upper bits set");
   property p_unmapped; ans && avs_address > usd_pkg::DIVISOR_ADDR |-> avs_readdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_one_line; sout || sirOutN; endproperty
   a_one_line: assert property (p_one_line) else $error("both outputs active");
   property p_mask; avs_write && !avs_waitrequest && avs_byteenable[0]
      && avs_address == usd_pkg::INT_MASK_ADDR && avs_writedata[2:0] == 3'h0 |=> !irq; endproperty
   a_mask: assert property (p_mask) else $error("irq despite full mask");
   property p_rst; disable iff (1'b0) rst |=> sout && sirOutN && !irq; endproperty
   a_rst: assert property (p_rst) else $error("outputs not idle after reset");
endmodule : usd_shadow_uart_props
bind usd_shadow_uart usd_shadow_uart_props chk_u (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sout(sout), .sirOutN(sirOutN), .irq(irq));

// >>> usd_line_model.sv
// remote serial transceiver, one tick per clock
`timescale 1ns/1ps
module usd_line_model (
   // clock, line
   input wire logic   clk_sys,
   input wire logic   sout,
   output logic       sin,
   // last character heard
   output logic [7:0] heard,
   output int         heardCnt
);
   initial sin = 1'h1;
   initial heardCnt = 0;
   task automatic send(input logic [7:0] c);
      for (int i = 0; i < 10; i++)
      begin
         sin <= i == 0 ? 1'h0 : i == 9 ? 1'h1 : c[i-1];
         repeat (16) @(posedge clk_sys);
      end
   endtask : send
   always
   begin
      @(negedge sout);
      repeat (24) @(posedge clk_sys);
      for (int i = 0; i < 8; i++)
      begin
         heard[i] = sout;
         repeat (16) @(posedge clk_sys);
      end
      heardCnt++;
   end
endmodule : usd_line_model

// >>> usd_shadow_uart_tb.sv
// self-checking bench for the shadow uart
`timescale 1ns/1ps
module usd_shadow_uart_tb;
   localparam logic [31:0] LS = usd_pkg::LINE_STATUS_ADDR;
   localparam logic [31:0] SH = usd_pkg::SHADOW_DATA1_ADDR;
   localparam logic [31:0] CT = usd_pkg::CTRL_ADDR;
   localparam logic [31:0] IM = usd_pkg::INT_MASK_ADDR;
   logic        clk_sys = 1'h0;
   logic        rst     = 1'h1;
   logic        rd      = 1'h0;
   logic        wr      = 1'h0;
   logic [31:0] adr     = 32'h0;
   logic [31:0] wd      = 32'h0;
   logic [31:0] rdata, q;
   logic        waitReq, sin, sout, sirOutN, irq;
   logic [7:0]  heard;
   int          heardCnt, numErrors = 0, numChecks = 0;
   usd_shadow_uart dut_u (.clk_sys(clk_sys), .rst(rst), .ce(1'h1), .avs_address(adr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdata),
      .avs_waitrequest(waitReq), .sin(sin), .sir_in(!sirOutN), .sout(sout), .sirOutN(sirOutN), .irq(irq));
   usd_line_model model_u (.clk_sys(clk_sys), .sout(sout), .sin(sin), .heard(heard), .heardCnt(heardCnt));
   initial forever #20 clk_sys = ~clk_sys;
   task automatic close_out;
      $display("checks %0d mismatches %0d", numChecks, numErrors);
      if (numErrors == 0 && numChecks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out
   task automatic chk(input string what, input logic [31:0] exp, got);
      numChecks++;
      if (got !== exp)
      begin
         numErrors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // held until waitrequest is low at a rising edge
   task automatic bus(input logic w, input logic [31:0] a, d);
      int   n = 0;
      logic ok = 1'h0;
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      while (!ok && n < 50)
      begin
         @(posedge clk_sys);
         n++;
         ok = waitReq === 1'h0;
         q = rdata;
      end
      rd <= 1'h0;
      wr <= 1'h0;
      @(posedge clk_sys);
      if (!ok)
      begin
         numErrors++;
         close_out();
      end
   endtask : bus
   task automatic hear(input int c);
      for (int n = 0; n < 4000 && heardCnt < c; n++)
         @(posedge clk_sys);
      repeat (200) @(posedge clk_sys);
      chk("heard count", c, heardCnt);
      if (heardCnt < c)
         close_out();
   endtask : hear
   task automatic t_reset;
      bus(0, LS, 32'h0); chk("status", 32'h60, q);
      bus(0, SH, 32'h0); chk("shadow", 32'h0, q);
      bus(0, 32'h5000_11A0, 32'h0); chk("unmapped", 32'h0, q);
      bus(1, usd_pkg::DIVISOR_ADDR, 32'h0);
      $display("test reset done");
   endtask : t_reset
   task automatic t_rx;
      model_u.send(8'hA5);
      bus(0, LS, 32'h0); chk("ready", 32'h61, q);
      bus(0, usd_pkg::SHADOW_LAST_ADDR, 32'h0); chk("rx", 32'hA5, q);
      bus(0, LS, 32'h0); chk("ready gone", 32'h60, q);
      model_u.send(8'h3C);
      model_u.send(8'hC3);
      bus(0, LS, 32'h0); chk("overrun", 32'h63, q);
      bus(0, SH, 32'h0); chk("overwrite", 32'hC3, q);
      $display("test rx done");
   endtask : t_rx
   task automatic t_fifo;
      bus(1, CT, 32'h1);
      for (int i = 0; i < 17; i++)
         model_u.send(8'h10 + i[7:0]);
      bus(0, LS, 32'h0); chk("fifo overrun", 32'h63, q);
      for (int i = 0; i < 16; i++)
      begin
         bus(0, usd_pkg::SHADOW_FIRST_ADDR + 32'(i * 4), 32'h0);
         chk("fifo head", 32'h10 + 32'(i), q);
      end
      bus(0, LS, 32'h0); chk("fifo empty", 32'h60, q);
      $display("test fifo done");
   endtask : t_fifo
   task automatic t_tx;
      for (int i = 0; i < 20; i++)
         bus(1, SH, 32'h40 + 32'(i));
      hear(17);
      chk("last sent", 32'h50, heard);
      bus(1, CT, 32'h0);
      bus(1, SH, 32'h71);
      bus(1, SH, 32'h72);
      bus(1, SH, 32'hFFFF_FF73);
      bus(0, LS, 32'h0); chk("holding full", 32'h0, q & 32'h20);
      hear(19);
      chk("overwritten", 32'h73, heard);
      bus(1, CT, 32'h2);
      bus(1, SH, 32'h5A);
      hear(19);
      bus(0, SH, 32'h0); chk("ir loop", 32'h5A, q);
      $display("test tx done");
   endtask : t_tx
   task automatic t_irq;
      bus(1, IM, 32'h7); chk("irq on", 32'h1, irq);
      bus(1, IM, 32'h0); chk("irq masked", 32'h0, irq);
      bus(1, IM, 32'h7);
      bus(1, usd_pkg::INT_STATUS_ADDR, 32'h7); chk("irq cleared", 32'h0, irq);
      bus(0, usd_pkg::INT_STATUS_ADDR, 32'h0); chk("int status", 32'h0, q);
      $display("test irq done");
   endtask : t_irq
   initial
   begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'h0;
      @(posedge clk_sys);
      t_reset();
      t_rx();
      t_fifo();
      t_tx();
      t_irq();
      close_out();
   end
endmodule : usd_shadow_uart_tb
